// ---- bch_defines.svh ----
// Constants of the bus-cycle handshake: widths, address map and storage sizes.
// Assumes inclusion by bare name from every file that needs them.
`ifndef BCH_DEFINES_SVH
`define BCH_DEFINES_SVH

`define BCH_DW          32
`define BCH_AW          32
`define BCH_SELW        4
`define BCH_GRAN        8
`define BCH_FIFO_DEPTH  32
`define BCH_MEM_WORDS   16
`define BCH_MEM_IDX_LSB 2
`define BCH_MEM_IDX_W   4
`define BCH_MEM_TOP_LSB 6
`define BCH_STREAM_ADR  32'h0000_0100
`define BCH_LEVEL_ADR   32'h0000_0104
`define BCH_LEN_W       4
`define BCH_ADR_STEP    32'h0000_0004
`define BCH_RST_DAT     32'h0000_0000

`endif

// ---- bch_pkg.sv ----
// Types of the bus-cycle handshake: command kinds and states for the master end, regions for the slave end.
// Assumes nothing of its surroundings.
package bch_pkg;

    typedef enum logic [1:0] {
        BCH_SINGLE,
        BCH_BLOCK,
        BCH_RMW
    } bch_kind_t;

    typedef enum logic [1:0] {
        BCH_REG_MEM,
        BCH_REG_STREAM,
        BCH_REG_LEVEL,
        BCH_REG_NONE
    } bch_region_t;

    typedef enum logic [1:0] {
        BCH_M_IDLE,
        BCH_M_RUN,
        BCH_M_NEXT
    } bch_mstate_t;

endpackage

// ---- bch_bus_if.sv ----
// Point-to-point bus between one master end and one slave end.
// Assumes both ends run on the same clock; all signals are one-way.
`timescale 1ns/1ps
`include "bch_defines.svh"

interface bch_bus_if;
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [`BCH_SELW-1:0]   sel;
    logic [`BCH_AW-1:0]     adr;
    logic [`BCH_DW-1:0]     dat_m2s;
    logic [`BCH_DW-1:0]     dat_s2m;
    logic                   ack;

    modport master (
        output cyc,
        output stb,
        output we,
        output sel,
        output adr,
        output dat_m2s,
        input  dat_s2m,
        input  ack
    );

    modport slave (
        input  cyc,
        input  stb,
        input  we,
        input  sel,
        input  adr,
        input  dat_m2s,
        output dat_s2m,
        output ack
    );
endinterface

// ---- bch_slave_end.sv ----
// Slave end: arbiter, 16-word byte-selectable memory, stream FIFO and level register.
// Assumes a master on the bus interface and a local requester on the same clock.
`timescale 1ns/1ps
`include "bch_defines.svh"

module bch_fifo #(
    parameter int W = `BCH_DW,
    parameter int D = `BCH_FIFO_DEPTH
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 in_valid,
    output logic                      in_ready,
    input  wire logic [W-1:0]         in_data,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [W-1:0]              out_data,
    output logic [$clog2(D):0]        level
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = cnt_q != D[AW:0];
    assign out_valid = cnt_q != '0;
    assign out_data  = mem_q[rd_q];
    assign level     = cnt_q;
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge core_clk) begin
        if (ce && push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (ce) begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end
endmodule

module bch_slave_end
    import bch_pkg::*;
#(
    parameter bit BIG_ENDIAN_BUS = 1'b0
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    bch_bus_if.slave                  bus,
    input  wire logic                 loc_cyc,
    output logic                      loc_grant,
    output logic                      out_valid,
    input  wire logic                 out_ready,
    output logic [`BCH_DW-1:0]        out_data
);
    // Addresses above the memory window select the stream and level words.
    function automatic bch_region_t decode(input logic [`BCH_AW-1:0] a);
        if (a[`BCH_AW-1:`BCH_MEM_TOP_LSB] == '0) begin
            return BCH_REG_MEM;
        end else if (a == `BCH_STREAM_ADR) begin
            return BCH_REG_STREAM;
        end else if (a == `BCH_LEVEL_ADR) begin
            return BCH_REG_LEVEL;
        end else begin
            return BCH_REG_NONE;
        end
    endfunction

    logic [`BCH_DW-1:0]              mem_q [`BCH_MEM_WORDS];
    logic [`BCH_DW-1:0]              rdat_q;
    logic                            ack_q;
    logic                            busy_q;
    logic                            owner_q;
    logic                            bus_grant;
    logic                            acc;
    logic                            ok;
    logic                            fifo_in_ready;
    logic [$clog2(`BCH_FIFO_DEPTH):0] fifo_level;
    logic [`BCH_SELW-1:0]            sel_le;
    logic [`BCH_DW-1:0]              wdat_le;
    logic [`BCH_MEM_IDX_W-1:0]       idx;
    bch_region_t                     region;

    // Byte order is fixed at build time, so the lane swap is only wiring.
    for (genvar i = 0; i < `BCH_SELW; i++) begin : g_lane
        localparam int J = BIG_ENDIAN_BUS ? (`BCH_SELW - 1 - i) : i;
        assign sel_le[i] = bus.sel[J];
        assign wdat_le[i*`BCH_GRAN +: `BCH_GRAN] = bus.dat_m2s[J*`BCH_GRAN +: `BCH_GRAN];
        assign bus.dat_s2m[J*`BCH_GRAN +: `BCH_GRAN] = rdat_q[i*`BCH_GRAN +: `BCH_GRAN];
    end

    assign bus_grant = busy_q & ~owner_q;
    assign loc_grant = busy_q & owner_q;
    assign region    = decode(bus.adr);
    // Operands never exceed the port width, so the word index needs no remapping.
    assign idx       = bus.adr[`BCH_MEM_IDX_LSB +: `BCH_MEM_IDX_W];
    assign acc       = bus.cyc & bus.stb & bus_grant & ~ack_q;
    assign ok        = ~(bus.we && region == BCH_REG_STREAM) | fifo_in_ready;
    assign bus.ack   = ack_q;

    // The owner keeps the grant while its cycle line stays high.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            busy_q  <= 1'b0;
            owner_q <= 1'b0;
        end else if (ce) begin
            if (busy_q) begin
                if (owner_q ? !loc_cyc : !bus.cyc) begin
                    busy_q <= 1'b0;
                end
            end else if (bus.cyc) begin
                busy_q  <= 1'b1;
                owner_q <= 1'b0;
            end else if (loc_cyc) begin
                busy_q  <= 1'b1;
                owner_q <= 1'b1;
            end
        end
    end

    // Acknowledge follows one edge after the access is decoded and accepted.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ack_q <= 1'b0;
        end else if (ce) begin
            ack_q <= acc & ok;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdat_q <= `BCH_RST_DAT;
        end else if (ce && acc && !bus.we) begin
            case (region)
                BCH_REG_MEM:    rdat_q <= mem_q[idx];
                BCH_REG_STREAM,
                BCH_REG_LEVEL:  rdat_q <= `BCH_DW'(fifo_level);
                default:        rdat_q <= `BCH_RST_DAT;
            endcase
        end
    end

    // Each byte of each word has its own process, so no two processes share a target.
    for (genvar w = 0; w < `BCH_MEM_WORDS; w++) begin : g_mem_word
        for (genvar b = 0; b < `BCH_SELW; b++) begin : g_mem_lane
            always_ff @(posedge core_clk) begin
                if (rst) begin
                    mem_q[w][b*`BCH_GRAN +: `BCH_GRAN] <= '0;
                end else if (ce && acc && bus.we && region == BCH_REG_MEM && sel_le[b]
                             && idx == `BCH_MEM_IDX_W'(w)) begin
                    mem_q[w][b*`BCH_GRAN +: `BCH_GRAN] <= wdat_le[b*`BCH_GRAN +: `BCH_GRAN];
                end
            end
        end
    end

    bch_fifo #(
        .W (`BCH_DW),
        .D (`BCH_FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (acc & bus.we & (region == BCH_REG_STREAM)),
        .in_ready  (fifo_in_ready),
        .in_data   (wdat_le),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data),
        .level     (fifo_level)
    );
endmodule

// ---- bch_master_end.sv ----
// Master end: turns user commands into single, block and atomic bus cycles.
// Assumes a slave end on the bus interface, same clock, no tag signals.
`timescale 1ns/1ps
`include "bch_defines.svh"

module bch_master_end
    import bch_pkg::*;
#(
    parameter bit BIG_ENDIAN_BUS = 1'b0
) (
    input  wire logic                 core_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    bch_bus_if.master                 bus,
    input  wire logic                 cmd_valid,
    output logic                      cmd_ready,
    input  wire bch_kind_t            cmd_kind,
    input  wire logic                 cmd_we,
    input  wire logic [`BCH_AW-1:0]   cmd_adr,
    input  wire logic [`BCH_SELW-1:0] cmd_sel,
    input  wire logic [`BCH_LEN_W-1:0] cmd_len,
    input  wire logic [`BCH_DW-1:0]   cmd_wdat,
    input  wire logic [`BCH_DW-1:0]   cmd_mask,
    output logic                      rd_valid,
    output logic [`BCH_DW-1:0]        rd_data,
    output logic                      wr_taken,
    output logic                      busy
);
    bch_mstate_t              state_q;
    bch_kind_t                kind_q;
    logic                     cyc_q;
    logic                     stb_q;
    logic                     we_q;
    logic [`BCH_SELW-1:0]     sel_q;
    logic [`BCH_AW-1:0]       adr_q;
    logic [`BCH_DW-1:0]       wdat_q;
    logic [`BCH_DW-1:0]       mask_q;
    logic [`BCH_LEN_W-1:0]    left_q;
    logic [`BCH_DW-1:0]       rdat_q;
    logic                     rd_valid_q;
    logic                     wr_taken_q;
    logic [`BCH_DW-1:0]       rdat_le;

    for (genvar i = 0; i < `BCH_SELW; i++) begin : g_lane
        localparam int J = BIG_ENDIAN_BUS ? (`BCH_SELW - 1 - i) : i;
        assign bus.sel[J] = sel_q[i];
        assign bus.dat_m2s[J*`BCH_GRAN +: `BCH_GRAN] = wdat_q[i*`BCH_GRAN +: `BCH_GRAN];
        assign rdat_le[i*`BCH_GRAN +: `BCH_GRAN] = bus.dat_s2m[J*`BCH_GRAN +: `BCH_GRAN];
    end

    assign bus.cyc   = cyc_q;
    assign bus.stb   = stb_q;
    assign bus.we    = we_q;
    assign bus.adr   = adr_q;
    assign cmd_ready = state_q == BCH_M_IDLE;
    assign busy      = cyc_q;
    assign rd_valid  = rd_valid_q;
    assign rd_data   = rdat_q;
    assign wr_taken  = wr_taken_q;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= BCH_M_IDLE;
            cyc_q   <= 1'b0;
            stb_q   <= 1'b0;
        end else if (ce) begin
            case (state_q)
                BCH_M_IDLE: begin
                    if (cmd_valid) begin
                        cyc_q   <= 1'b1;
                        stb_q   <= 1'b1;
                        state_q <= BCH_M_RUN;
                    end
                end
                BCH_M_RUN: begin
                    if (bus.ack) begin
                        stb_q <= 1'b0;
                        if (left_q == '0) begin
                            cyc_q   <= 1'b0;
                            state_q <= BCH_M_IDLE;
                        end else begin
                            state_q <= BCH_M_NEXT;
                        end
                    end
                end
                BCH_M_NEXT: begin
                    stb_q   <= 1'b1;
                    state_q <= BCH_M_RUN;
                end
                default: begin
                    state_q <= BCH_M_IDLE;
                end
            endcase
        end
    end

    // Phase attributes change only at acceptance or at an acknowledge edge.
    always_ff @(posedge core_clk) begin
        if (rst) begin
            kind_q <= BCH_SINGLE;
            we_q   <= 1'b0;
            sel_q  <= '0;
            adr_q  <= '0;
            wdat_q <= `BCH_RST_DAT;
            mask_q <= `BCH_RST_DAT;
            left_q <= '0;
        end else if (ce) begin
            if (state_q == BCH_M_IDLE && cmd_valid) begin
                kind_q <= cmd_kind;
                we_q   <= (cmd_kind == BCH_RMW) ? 1'b0 : cmd_we;
                sel_q  <= cmd_sel;
                adr_q  <= cmd_adr;
                wdat_q <= cmd_wdat;
                mask_q <= cmd_mask;
                case (cmd_kind)
                    BCH_SINGLE: left_q <= '0;
                    BCH_RMW:    left_q <= `BCH_LEN_W'(1);
                    default:    left_q <= (cmd_len == '0) ? `BCH_LEN_W'(1) : cmd_len;
                endcase
            end else if (state_q == BCH_M_RUN && bus.ack && left_q != '0) begin
                left_q <= left_q - `BCH_LEN_W'(1);
                if (kind_q == BCH_RMW) begin
                    we_q   <= 1'b1;
                    wdat_q <= (rdat_le & ~mask_q) | (wdat_q & mask_q);
                end else begin
                    adr_q <= adr_q + `BCH_ADR_STEP;
                    if (we_q) begin
                        wdat_q <= cmd_wdat;
                    end
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdat_q     <= `BCH_RST_DAT;
            rd_valid_q <= 1'b0;
            wr_taken_q <= 1'b0;
        end else if (ce) begin
            rd_valid_q <= (state_q == BCH_M_RUN) & bus.ack & ~we_q;
            wr_taken_q <= (state_q == BCH_M_RUN) & bus.ack & we_q;
            if (state_q == BCH_M_RUN && bus.ack && !we_q) begin
                rdat_q <= rdat_le;
            end
        end
    end
endmodule

// ---- bch_properties.sv ----
// Concurrent checks on the bus that joins the master end to the slave end.
// Assumes instantiation in the testbench top beside the interface, on core_clk.
`timescale 1ns/1ps
`include "bch_defines.svh"

module bch_properties (
    input wire logic                 core_clk,
    input wire logic                 rst,
    input wire logic                 cyc,
    input wire logic                 stb,
    input wire logic                 we,
    input wire logic [`BCH_SELW-1:0] sel,
    input wire logic [`BCH_AW-1:0]   adr,
    input wire logic [`BCH_DW-1:0]   dat_m2s,
    input wire logic [`BCH_DW-1:0]   dat_s2m,
    input wire logic                 ack,
    input wire logic                 loc_grant
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // A phase that follows an acknowledge inside one cycle steps the address, except the write of an atomic pair.
    sequence next_phase_s;
        ack && cyc ##1 cyc && !stb ##1 stb;
    endsequence

    AST_RESET_IDLE: assert property (disable iff (1'b0) rst |=> !cyc && !stb && !ack)
        else $error("bus not idle after reset");
    AST_STB_IN_CYC: assert property (stb |-> cyc)
        else $error("strobe outside cycle");
    AST_ACK_IN_PHASE: assert property (ack |-> stb && cyc)
        else $error("acknowledge without strobe");
    AST_ACK_PULSE: assert property (ack |=> !ack && !stb)
        else $error("acknowledge or strobe held after acknowledge");
    AST_ACK_WAIT: assert property ($rose(stb) |-> !ack)
        else $error("acknowledge in first strobe cycle");
    AST_ACK_BOUND: assert property ($rose(stb) |-> ##[1:200] ack)
        else $error("strobe never acknowledged");
    AST_HOLD: assert property (stb && !ack |=> stb && $stable(adr) && $stable(we) && $stable(sel) && $stable(dat_m2s))
        else $error("request changed before acknowledge");
    AST_PHASE_ADR: assert property (next_phase_s |-> adr == $past(adr, 2) + `BCH_ADR_STEP
        || (we && !$past(we, 2) && adr == $past(adr, 2)))
        else $error("wrong address for next phase");
    AST_CYC_END: assert property ($fell(cyc) |-> $past(ack))
        else $error("cycle ended before final acknowledge");
    AST_GRANT_EXCL: assert property (loc_grant |-> !ack)
        else $error("master acknowledged while local owns bus");
    AST_RDATA_HOLD: assert property (!(stb && !we) |=> $stable(dat_s2m))
        else $error("read data changed outside a read phase");

    CV_WRITE: cover property (ack && we);
    CV_READ: cover property (ack && !we);
    CV_LOCAL: cover property (loc_grant && cyc);
    CV_RMW: cover property (ack && !we ##2 stb && we);
endmodule

// ---- test_bus_cycle_handshake.sv ----
// Testbench: master end and slave end joined by the bus interface, driven from the user sides.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/1ps
`include "bch_defines.svh"

module test_bus_cycle_handshake
    import bch_pkg::*;
;
    logic              core_clk;
    logic              rst;
    logic              ce;
    logic              cmd_valid;
    logic              cmd_ready;
    bch_kind_t         cmd_kind;
    logic              cmd_we;
    logic [31:0]       cmd_adr;
    logic [3:0]        cmd_sel;
    logic [3:0]        cmd_len;
    logic [31:0]       cmd_wdat;
    logic [31:0]       cmd_mask;
    logic              rd_valid;
    logic [31:0]       rd_data;
    logic              wr_taken;
    logic              busy;
    logic              loc_cyc;
    logic              loc_grant;
    logic              out_valid;
    logic              out_ready;
    logic [31:0]       out_data;
    logic [31:0]       rd_q[$];
    logic [31:0]       wr_cnt;
    logic [31:0]       i;
    int                p;
    int                error_cnt;
    int                n_compared;
    int                cyc_cnt;

    bch_bus_if bch_bus_if_inst ();

    bch_master_end bch_master_end_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .bus(bch_bus_if_inst.master),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_we(cmd_we),
        .cmd_adr(cmd_adr), .cmd_sel(cmd_sel), .cmd_len(cmd_len), .cmd_wdat(cmd_wdat),
        .cmd_mask(cmd_mask), .rd_valid(rd_valid), .rd_data(rd_data), .wr_taken(wr_taken), .busy(busy)
    );

    bch_slave_end bch_slave_end_inst (
        .core_clk(core_clk), .rst(rst), .ce(ce), .bus(bch_bus_if_inst.slave),
        .loc_cyc(loc_cyc), .loc_grant(loc_grant), .out_valid(out_valid),
        .out_ready(out_ready), .out_data(out_data)
    );

    bch_properties bch_properties_inst (
        .core_clk(core_clk), .rst(rst), .cyc(bch_bus_if_inst.cyc), .stb(bch_bus_if_inst.stb),
        .we(bch_bus_if_inst.we), .sel(bch_bus_if_inst.sel), .adr(bch_bus_if_inst.adr),
        .dat_m2s(bch_bus_if_inst.dat_m2s), .dat_s2m(bch_bus_if_inst.dat_s2m),
        .ack(bch_bus_if_inst.ack), .loc_grant(loc_grant)
    );

    always #2.5 core_clk = ~core_clk;

    // Read words and write completions are collected mid-cycle, where the pulses are settled.
    always @(negedge core_clk) begin
        if (rd_valid === 1'b1) rd_q.push_back(rd_data);
        if (wr_taken === 1'b1) wr_cnt <= wr_cnt + 32'h1;
    end

    always @(posedge core_clk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [31:0] pop();
        if (rd_q.size() == 0) return 32'hXXXXXXXX;
        return rd_q.pop_front();
    endfunction

    // Issues one command and returns once the bus cycle has ended; write data advances by one per acknowledge.
    task automatic run(input bch_kind_t k, input logic w, input logic [31:0] a, input logic [3:0] s,
                       input logic [3:0] n, input logic [31:0] d, input logic [31:0] m);
        int t;
        @(negedge core_clk);
        cmd_kind  = k;
        cmd_we    = w;
        cmd_adr   = a;
        cmd_sel   = s;
        cmd_len   = n;
        cmd_wdat  = d;
        cmd_mask  = m;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) @(negedge core_clk);
        @(negedge core_clk);
        cmd_valid = 1'b0;
        for (t = 0; t < 300 && busy === 1'b1; t++) begin
            if (bch_bus_if_inst.ack === 1'b1) cmd_wdat = cmd_wdat + 32'h1;
            @(negedge core_clk);
        end
        check({31'h0, busy}, 32'h0);
        @(negedge core_clk);
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        run(BCH_SINGLE, 1'b0, a, 4'hF, 4'h0, 32'h0, 32'h0);
        check(pop(), exp);
    endtask

    initial begin
        core_clk = 1'b0;
        rst = 1'b1;
        ce = 1'b1;
        cmd_valid = 1'b0;
        cmd_kind = BCH_SINGLE;
        cmd_we = 1'b0;
        cmd_adr = 32'h0;
        cmd_sel = 4'h0;
        cmd_len = 4'h0;
        cmd_wdat = 32'h0;
        cmd_mask = 32'h0;
        loc_cyc = 1'b0;
        out_ready = 1'b0;
        wr_cnt = 32'h0;
        error_cnt = 0;
        n_compared = 0;
        cyc_cnt = 0;
        repeat (10) @(posedge core_clk);
        @(negedge core_clk);
        rst = 1'b0;
        check({26'h0, bch_bus_if_inst.cyc, bch_bus_if_inst.stb, bch_bus_if_inst.ack,
               cmd_ready, loc_grant, out_valid}, 32'h4);
        // A request presented while the clock enable is low must not be taken.
        ce = 1'b0;
        cmd_valid = 1'b1;
        repeat (3) @(negedge core_clk);
        check({31'h0, busy}, 32'h0);
        cmd_valid = 1'b0;
        ce = 1'b1;
        run(BCH_SINGLE, 1'b1, 32'h0, 4'hF, 4'h0, 32'h12345678, 32'h0);
        rd(32'h0, 32'h12345678);
        run(BCH_SINGLE, 1'b1, 32'h0, 4'h2, 4'h0, 32'hAABBCCDD, 32'h0);
        rd(32'h0, 32'h1234CC78);
        wr_cnt = 32'h0;
        run(BCH_BLOCK, 1'b1, 32'h10, 4'hF, 4'h3, 32'h100, 32'h0);
        check(wr_cnt, 32'h4);
        run(BCH_BLOCK, 1'b0, 32'h10, 4'hF, 4'h3, 32'h0, 32'h0);
        for (i = 0; i < 4; i++) check(pop(), 32'h100 + i);
        run(BCH_RMW, 1'b0, 32'h10, 4'hF, 4'h0, 32'h5555BEEF, 32'h0000FFFF);
        check(pop(), 32'h100);
        rd(32'h10, 32'h0000BEEF);
        run(BCH_SINGLE, 1'b1, 32'h200, 4'hF, 4'h0, 32'hFFFFFFFF, 32'h0);
        rd(32'h200, 32'h0);
        loc_cyc = 1'b1;
        repeat (3) @(negedge core_clk);
        check({31'h0, loc_grant}, 32'h1);
        fork
            rd(32'h14, 32'h101);
            begin
                repeat (20) @(negedge core_clk);
                check({30'h0, loc_grant, busy}, 32'h3);
                loc_cyc = 1'b0;
            end
        join
        fork
            run(BCH_BLOCK, 1'b0, 32'h0, 4'hF, 4'hF, 32'h0, 32'h0);
            begin
                repeat (6) @(negedge core_clk);
                loc_cyc = 1'b1;
                repeat (20) @(negedge core_clk);
                check({30'h0, loc_grant, busy}, 32'h1);
            end
        join
        loc_cyc = 1'b0;
        check(rd_q.size(), 32'h10);
        rd_q.delete();
        for (i = 0; i < 32; i++) begin
            run(BCH_SINGLE, 1'b1, `BCH_STREAM_ADR, 4'hF, 4'h0, 32'hA000 + i, 32'h0);
        end
        rd(`BCH_LEVEL_ADR, 32'h20);
        fork
            run(BCH_SINGLE, 1'b1, `BCH_STREAM_ADR, 4'hF, 4'h0, 32'hA020, 32'h0);
            begin
                repeat (10) @(negedge core_clk);
                check({31'h0, busy}, 32'h1);
                out_ready = 1'b1;
                i = 0;
                for (p = 0; p < 300 && i < 33; p++) begin
                    if (out_valid === 1'b1) begin
                        check(out_data, 32'hA000 + i);
                        i++;
                    end
                    @(negedge core_clk);
                end
                check(i, 32'h21);
            end
        join
        check({31'h0, out_valid}, 32'h0);
        report_and_stop();
    end
endmodule
